//--- core/ssl_top.sv
// Serial programming port, latches, loop enables and output multiplexer.
//
// Operation
// - Shift data on each serial clock rise while load strobe is low.
// - Last two bits select destination latch.
// - Load strobe rise copies word into latch.
// - RF enable low powers down RF loop.
// - RF enable high obeys RF control field.
// - IF enable low powers down IF loop.
// - IF enable high obeys IF control field.
// - Routing bit gates reference to RF R counter; IF R counter always gets it.
// - Mux output selects divider or lock indication.
// - Mux output push-pull except analog lock mode.
// - Second aux output follows IF word bit 18.
// - First aux output follows IF word bit 17.
`timescale 1ns/1ps
`default_nettype none
module ssl_top (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_serial_clk,
  input  wire logic                     i_serial_data,
  input  wire logic                     i_load_strobe,
  input  wire logic                     i_rf_loop_enable,
  input  wire logic                     i_if_loop_enable,
  input  wire logic                     i_reference_osc_input,
  input  wire logic                     i_rf_n_div,
  input  wire logic                     i_if_n_div,
  input  wire logic                     i_rf_r_div,
  input  wire logic                     i_if_r_div,
  input  wire logic                     i_rf_lock,
  input  wire logic                     i_if_lock,
  input  wire logic                     i_analog_lock_n,
  output logic                          o_rf_loop_powered,
  output logic                          o_if_loop_powered,
  output logic                          o_rf_pump_oe,
  output logic                          o_if_pump_output_oe,
  output logic                          o_rf_r_ref,
  output logic                          o_if_r_ref,
  output logic                          o_mux_lock_output,
  output logic                          o_mux_lock_output_oe,
  output logic                          o_aux_output_first,
  output logic                          o_aux_output_second,
  output logic [ssl_pkg::WORD_W-1:0]    o_rf_r_word,
  output logic [ssl_pkg::WORD_W-1:0]    o_rf_n_word,
  output logic [ssl_pkg::WORD_W-1:0]    o_if_r_word,
  output logic [ssl_pkg::WORD_W-1:0]    o_if_n_word
);
  // ****************************************
  // Link domain: shift register and load
  // ****************************************
  // The shift register lives on the serial clock; it has no reset of its own,
  // so it is cleared only through the core reset to keep simulation defined.
  logic [ssl_pkg::WORD_W-1:0] shift_r;
  logic [ssl_pkg::WORD_W-1:0] shift_nxt;

  always_comb begin
    shift_nxt = {shift_r[ssl_pkg::WORD_W-2:0], i_serial_data};
  end

  always_ff @(posedge i_serial_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= ssl_pkg::LATCH_RST;
    end else if (!i_load_strobe) begin
      shift_r <= shift_nxt;
    end
  end

  // ****************************************
  // Core domain: strobe synchroniser and load pulse
  // ****************************************
  // The strobe is a level that the host holds while the serial clock is idle,
  // so the shift register is stable when the synchronised edge samples it.
  logic [3:0] le_sync_r;
  logic [3:0] le_sync_nxt;
  logic       load_rise;

  // Bits 0 and 1 are the synchroniser; bits 2 and 3 only time the load, so
  // the load always uses a word that was captured one cycle earlier.
  always_comb begin
    le_sync_nxt = {le_sync_r[2:0], i_load_strobe};
    load_rise   = le_sync_r[2] && !le_sync_r[3];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      le_sync_r <= 4'h0;
    end else begin
      le_sync_r <= le_sync_nxt;
    end
  end

  // ****************************************
  // Core domain: word capture and latches
  // ****************************************
  logic [ssl_pkg::WORD_W-1:0] word_cap_r;
  logic [ssl_pkg::WORD_W-1:0] word_cap_nxt;

  // The word is taken only while the synchronised strobe is high, when the
  // host keeps the serial clock still and the shift register cannot move.
  always_comb begin
    word_cap_nxt = word_cap_r;
    if (le_sync_r[1]) begin
      word_cap_nxt = shift_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_cap_r <= ssl_pkg::LATCH_RST;
    end else begin
      word_cap_r <= word_cap_nxt;
    end
  end

  logic [ssl_pkg::WORD_W-1:0] latch_r   [ssl_pkg::NUM_LATCH];
  logic [ssl_pkg::WORD_W-1:0] latch_nxt [ssl_pkg::NUM_LATCH];

  always_comb begin
    for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
      latch_nxt[i] = latch_r[i];
    end
    if (load_rise) begin
      latch_nxt[word_cap_r[ssl_pkg::SEL_W-1:0]] = word_cap_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
        latch_r[i] <= ssl_pkg::LATCH_RST;
      end
    end else begin
      for (int i = 0; i < ssl_pkg::NUM_LATCH; i++) begin
        latch_r[i] <= latch_nxt[i];
      end
    end
  end

  // ****************************************
  // Enable pin synchronisers
  // ****************************************
  logic [1:0] rf_loop_enable_sync_r;
  logic [1:0] rf_loop_enable_sync_nxt;
  logic [1:0] if_en_sync_r;
  logic [1:0] if_en_sync_nxt;
  logic [1:0] alock_sync_r;
  logic [1:0] alock_sync_nxt;

  always_comb begin
    rf_loop_enable_sync_nxt = {rf_loop_enable_sync_r[0], i_rf_loop_enable};
    if_en_sync_nxt = {if_en_sync_r[0], i_if_loop_enable};
    alock_sync_nxt = {alock_sync_r[0], i_analog_lock_n};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rf_loop_enable_sync_r <= 2'h0;
      if_en_sync_r <= 2'h0;
      alock_sync_r <= 2'h3;
    end else begin
      rf_loop_enable_sync_r <= rf_loop_enable_sync_nxt;
      if_en_sync_r <= if_en_sync_nxt;
      alock_sync_r <= alock_sync_nxt;
    end
  end

  // ****************************************
  // Loop power, routing and output registers
  // ****************************************
  logic [ssl_pkg::CTL_W-1:0] rf_ctl;
  logic [ssl_pkg::CTL_W-1:0] if_ctl;
  logic [ssl_pkg::MUX_W-1:0] mux_sel;
  logic                      osc_both;
  logic                      rf_pwr_r;
  logic                      rf_pwr_nxt;
  logic                      if_pwr_r;
  logic                      if_pwr_nxt;

  // Field decode is plain wiring of the latched words.
  always_comb begin
    rf_ctl   = latch_r[ssl_pkg::SEL_RF_R][ssl_pkg::CTL_LSB +: ssl_pkg::CTL_W];
    if_ctl   = latch_r[ssl_pkg::SEL_IF_R][ssl_pkg::CTL_LSB +: ssl_pkg::CTL_W];
    mux_sel  = latch_r[ssl_pkg::SEL_IF_R][ssl_pkg::MUX_LSB +: ssl_pkg::MUX_W];
    osc_both = latch_r[ssl_pkg::SEL_IF_R][ssl_pkg::OSC_ROUTE_BIT];
  end

  // A nonzero control field permits power-up; zero keeps the loop down even
  // with the pin high, so a loop can be parked without touching its pin.
  always_comb begin
    rf_pwr_nxt = rf_loop_enable_sync_r[1] && (rf_ctl != '0);
    if_pwr_nxt = if_en_sync_r[1] && (if_ctl != '0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rf_pwr_r <= 1'b0;
      if_pwr_r <= 1'b0;
    end else begin
      rf_pwr_r <= rf_pwr_nxt;
      if_pwr_r <= if_pwr_nxt;
    end
  end

  // ****************************************
  // General-purpose outputs
  // ****************************************
  logic aux1_r;
  logic aux1_nxt;
  logic aux2_r;
  logic aux2_nxt;

  always_comb begin
    aux1_nxt = latch_r[ssl_pkg::SEL_IF_N][ssl_pkg::AUX_FIRST_BIT];
    aux2_nxt = latch_r[ssl_pkg::SEL_IF_N][ssl_pkg::AUX_SECOND_BIT];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux1_r <= 1'b0;
      aux2_r <= 1'b0;
    end else begin
      aux1_r <= aux1_nxt;
      aux2_r <= aux2_nxt;
    end
  end

  // ****************************************
  // Multiplexed output
  // ****************************************
  logic mux_r;
  logic mux_nxt;
  logic mux_oe_r;
  logic mux_oe_nxt;

  // Every selection but the analog one drives both levels.
  always_comb begin
    mux_nxt    = 1'b0;
    mux_oe_nxt = 1'b1;
    case (mux_sel)
      ssl_pkg::MUX_ZERO: begin
        mux_nxt    = 1'b0;
        mux_oe_nxt = 1'b1;
      end
      ssl_pkg::MUX_RF_LOCK: begin
        mux_nxt    = i_rf_lock;
        mux_oe_nxt = 1'b1;
      end
      ssl_pkg::MUX_IF_LOCK: begin
        mux_nxt    = i_if_lock;
        mux_oe_nxt = 1'b1;
      end
      ssl_pkg::MUX_N_DIV: begin
        mux_nxt    = i_rf_n_div | i_if_n_div;
        mux_oe_nxt = 1'b1;
      end
      ssl_pkg::MUX_R_DIV: begin
        mux_nxt    = i_rf_r_div | i_if_r_div;
        mux_oe_nxt = 1'b1;
      end
      ssl_pkg::MUX_ANALOG: begin
        // Open drain: drive low only, release otherwise.
        mux_nxt    = 1'b0;
        mux_oe_nxt = !alock_sync_r[1];
      end
      ssl_pkg::MUX_ONE: begin
        mux_nxt    = 1'b1;
        mux_oe_nxt = 1'b1;
      end
      default: begin
        mux_nxt    = 1'b0;
        mux_oe_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mux_r    <= 1'b0;
      mux_oe_r <= 1'b1;
    end else begin
      mux_r    <= mux_nxt;
      mux_oe_r <= mux_oe_nxt;
    end
  end

  // ****************************************
  // Reference routing and port drive
  // ****************************************
  // Reference routing is a plain gate on purpose: the oscillator is a clock
  // and must not be resampled by the core clock.
  assign o_if_r_ref           = i_reference_osc_input;
  assign o_rf_r_ref           = i_reference_osc_input & osc_both;
  assign o_rf_loop_powered    = rf_pwr_r;
  assign o_if_loop_powered    = if_pwr_r;
  assign o_rf_pump_oe         = rf_pwr_r;
  assign o_if_pump_output_oe  = if_pwr_r;
  assign o_mux_lock_output    = mux_r;
  assign o_mux_lock_output_oe = mux_oe_r;
  assign o_aux_output_first   = aux1_r;
  assign o_aux_output_second  = aux2_r;
  assign o_rf_r_word          = latch_r[ssl_pkg::SEL_RF_R];
  assign o_rf_n_word          = latch_r[ssl_pkg::SEL_RF_N];
  assign o_if_r_word          = latch_r[ssl_pkg::SEL_IF_R];
  assign o_if_n_word          = latch_r[ssl_pkg::SEL_IF_N];
endmodule
`default_nettype wire

//--- include/ssl_pkg.sv
// Shared constants for the synthesizer serial load and enable block.
package ssl_pkg;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int unsigned WORD_W    = 24;
  localparam int unsigned SEL_W     = 2;
  localparam int unsigned NUM_LATCH = 4;
  localparam int unsigned CTL_W     = 4;
  localparam int unsigned MUX_W     = 3;
  // Destination selector codes held in the two last bits.
  localparam logic [1:0] SEL_RF_R = 2'h0;
  localparam logic [1:0] SEL_RF_N = 2'h1;
  localparam logic [1:0] SEL_IF_R = 2'h2;
  localparam logic [1:0] SEL_IF_N = 2'h3;
  // Field positions inside the latched words.
  localparam int unsigned AUX_FIRST_BIT  = 17;
  localparam int unsigned AUX_SECOND_BIT = 18;
  localparam int unsigned OSC_ROUTE_BIT  = 2;
  localparam int unsigned CTL_LSB        = 3;
  localparam int unsigned MUX_LSB        = 7;
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
  // Output multiplexer selection codes.
  localparam logic [2:0] MUX_ZERO     = 3'h0;
  localparam logic [2:0] MUX_RF_LOCK  = 3'h1;
  localparam logic [2:0] MUX_IF_LOCK  = 3'h2;
  localparam logic [2:0] MUX_N_DIV    = 3'h3;
  localparam logic [2:0] MUX_R_DIV    = 3'h4;
  localparam logic [2:0] MUX_ANALOG   = 3'h5;
  localparam logic [2:0] MUX_ONE      = 3'h6;
endpackage

//--- tb/ssl_props.sv
// Checker for the serial load and enable block.
`timescale 1ns/1ps
`default_nettype none
module ssl_props (
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  input wire logic                       i_rf_loop_enable,
  input wire logic                       i_if_loop_enable,
  input wire logic                       i_reference_osc_input,
  input wire logic                       i_rf_lock,
  input wire logic                       o_rf_loop_powered,
  input wire logic                       o_if_loop_powered,
  input wire logic                       o_rf_pump_oe,
  input wire logic                       o_if_pump_output_oe,
  input wire logic                       o_rf_r_ref,
  input wire logic                       o_if_r_ref,
  input wire logic                       o_mux_lock_output,
  input wire logic                       o_mux_lock_output_oe,
  input wire logic                       o_aux_output_first,
  input wire logic                       o_aux_output_second,
  input wire logic [ssl_pkg::WORD_W-1:0] o_rf_r_word,
  input wire logic [ssl_pkg::WORD_W-1:0] o_if_r_word,
  input wire logic [ssl_pkg::WORD_W-1:0] o_if_n_word
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_rf_power_down: assert property (
    !i_rf_loop_enable [*4] |-> !o_rf_loop_powered && !o_rf_pump_oe) else $error("rf loop on");
  a_if_power_down: assert property (
    !i_if_loop_enable [*4] |-> !o_if_loop_powered && !o_if_pump_output_oe) else $error("if loop on");
  a_rf_ctl_gate: assert property (
    o_rf_loop_powered |-> $past(o_rf_r_word[6:3]) != 4'h0) else $error("rf ctl zero");
  a_if_ctl_gate: assert property (
    o_if_loop_powered |-> $past(o_if_r_word[6:3]) != 4'h0) else $error("if ctl zero");
  a_ref_route: assert property (
    o_if_r_ref == i_reference_osc_input && o_rf_r_ref == (i_reference_osc_input && o_if_r_word[2]))
    else $error("ref route");
  a_aux_levels: assert property (
    {o_aux_output_second, o_aux_output_first} == $past(o_if_n_word[18:17])) else $error("aux level");
  a_mux_push_pull: assert property (
    $past(o_if_r_word[9:7]) != 3'h5 |-> o_mux_lock_output_oe) else $error("mux not driven");
  a_mux_rf_lock: assert property (
    $past(o_if_r_word[9:7]) == 3'h1 |-> o_mux_lock_output == $past(i_rf_lock)) else $error("mux lock");
  a_mux_analog_low: assert property (
    $past(o_if_r_word[9:7]) == 3'h5 |-> !o_mux_lock_output) else $error("mux analog high");
endmodule
bind ssl_top ssl_props props_u (.*);
`default_nettype wire

//--- tb/ssl_host.sv
// Host model that shifts words into the serial port.
`timescale 1ns/1ps
`default_nettype none
module ssl_host (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_strobe
);
  initial {o_sclk, o_sdata, o_strobe} = 3'h0;
  // Clock idles between words and data flips after, so no stale level passes for a bit.
  task automatic send(input logic [23:0] w);
    for (int b = 23; b >= 0; b--) begin
      #16 o_sdata = w[b];
      #16 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    #10 o_sdata = ~o_sdata;
    #10 o_strobe = 1'b1;
    #40 o_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/ssl_top_test.sv
// Self-checking bench for the serial load and enable block.
`timescale 1ns/1ps
`default_nettype none
module ssl_top_test;
  logic        clk = 0, rst_n = 0, rf_loop_enable = 0, if_en = 0, an_n = 1;
  logic [6:0]  rnd = '0;
  logic        sclk, sdata, strobe, rf_pw, if_pw, mux, mux_oe, aux1, aux2;
  logic [23:0] wd [4];
  logic [23:0] exp_w [4];
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) rnd <= 7'($urandom);
  ssl_host host_u (.o_sclk(sclk), .o_sdata(sdata), .o_strobe(strobe));
  ssl_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_serial_clk(sclk), .i_serial_data(sdata),
    .i_load_strobe(strobe), .i_rf_loop_enable(rf_loop_enable), .i_if_loop_enable(if_en),
    .i_reference_osc_input(rnd[0]), .i_rf_n_div(rnd[1]), .i_if_n_div(rnd[2]), .i_rf_r_div(rnd[3]),
    .i_if_r_div(rnd[4]), .i_rf_lock(rnd[5]), .i_if_lock(rnd[6]), .i_analog_lock_n(an_n),
    .o_rf_loop_powered(rf_pw), .o_if_loop_powered(if_pw), .o_rf_pump_oe(), .o_if_pump_output_oe(),
    .o_rf_r_ref(), .o_if_r_ref(), .o_mux_lock_output(mux), .o_mux_lock_output_oe(mux_oe),
    .o_aux_output_first(aux1), .o_aux_output_second(aux2), .o_rf_r_word(wd[0]),
    .o_rf_n_word(wd[1]), .o_if_r_word(wd[2]), .o_if_n_word(wd[3]));
  function automatic logic pw_exp(input logic en, input logic [23:0] w);
    return en && (w[6:3] != 4'h0);
  endfunction
  // Returns drive enable above level, from the sources sampled at the last edge.
  function automatic logic [1:0] mux_exp(input logic [2:0] code, input logic an, input logic [6:0] r);
    case (code)
      ssl_pkg::MUX_RF_LOCK: return {1'b1, r[5]};
      ssl_pkg::MUX_IF_LOCK: return {1'b1, r[6]};
      ssl_pkg::MUX_N_DIV:   return {1'b1, r[1] | r[2]};
      ssl_pkg::MUX_R_DIV:   return {1'b1, r[3] | r[4]};
      ssl_pkg::MUX_ANALOG:  return {~an, 1'b0};
      ssl_pkg::MUX_ONE:     return 2'h3;
      default:              return 2'h2;
    endcase
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    logic [23:0] w;
    void'($urandom(32'hafe5));
    for (int k = 0; k < 4; k++) exp_w[k] = ssl_pkg::LATCH_RST;
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      // A reset in mid-run must clear every latch and let loading resume.
      if (i == 20) begin
        rst_n = 0;
        repeat (2) @(negedge clk);
        check(wd[0] | wd[1] | wd[2] | wd[3], 24'h0);
        rst_n = 1;
        for (int k = 0; k < 4; k++) exp_w[k] = ssl_pkg::LATCH_RST;
      end
      {rf_loop_enable, if_en, an_n} = 3'($urandom);
      w = 24'($urandom);
      w[1:0] = i[1:0];
      if (i < 32) w[9:7] = i[4:2];
      // Zero control field with the pin high must still keep the loop down.
      if (i == 4 || i == 6) begin
        w[6:3] = 4'h0;
        {rf_loop_enable, if_en} = 2'h3;
      end
      host_u.send(w);
      exp_w[i % 4] = w;
      repeat (10) @(negedge clk);
      for (int k = 0; k < 4; k++) check(wd[k], exp_w[k]);
      check(24'({rf_pw, if_pw}), 24'({pw_exp(rf_loop_enable, exp_w[0]), pw_exp(if_en, exp_w[2])}));
      check(24'({aux2, aux1}), 24'(exp_w[3][18:17]));
      check(24'({mux_oe, mux}), 24'(mux_exp(exp_w[2][9:7], an_n, rnd)));
    end
    @(negedge clk) rst_n = 0;
    @(negedge clk) check(wd[0] | wd[1] | wd[2] | wd[3], 24'h0);
    stop_test();
  end
endmodule
`default_nettype wire
